// file: smle_pkg.sv
// smle_pkg: opcodes, field positions, widths and constants for the shift/move/literal executor
// assumes: used by smle_exec and smle_ptr_step; nothing imported, all uses are qualified
package smle_pkg;

	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 7;
	localparam int PTR_W    = 16;
	localparam int BANK_W   = 5;
	localparam int PCH_W    = 7;
	localparam int OFFS_W   = 6;

	// instruction selector presented by the decode stage
	typedef enum logic [2:0] {
		SMLE_OP_NONE      = 3'h0,
		SMLE_OP_LSR       = 3'h1,
		SMLE_OP_MOVE_FILE = 3'h2,
		SMLE_OP_IND_LOAD  = 3'h3,
		SMLE_OP_LOAD_BANK = 3'h4,
		SMLE_OP_LOAD_PCH  = 3'h5,
		SMLE_OP_LOAD_WORK = 3'h6
	} smle_op_e;

	// pointer_mode_code
	localparam logic [1:0] MODE_PRE_INC  = 2'h0;
	localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
	localparam logic [1:0] MODE_POST_INC = 2'h2;
	localparam logic [1:0] MODE_POST_DEC = 2'h3;

	// indirect_window addresses: file addresses that redirect through a pointer
	localparam logic [6:0] IND_WIN0_ADDR = 7'h00;
	localparam logic [6:0] IND_WIN1_ADDR = 7'h01;

	localparam logic       DEST_WORK     = 1'h0;
	localparam logic [7:0] DATA_ZERO     = 8'h00;
	localparam logic [15:0] PTR_ONE      = 16'h0001;
	localparam logic [15:0] PTR_RESET    = 16'h0000;
	localparam logic [4:0] BANK_RESET    = 5'h00;
	localparam logic [6:0] PCH_RESET     = 7'h00;
	localparam logic [4:0] BANK_LIT_MASK = 5'h0F;

	localparam int LSB = 0;
	localparam int MSB = DATA_W - 1;

endpackage

// file: smle_ptr_step.sv
// smle_ptr_step: effective address and written-back value of one file pointer
// assumes: purely combinational, fed by smle_exec on the same clock
`timescale 1ns/1ns
`default_nettype none

module smle_ptr_step (
	input  wire logic [15:0] ptr_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic        rel_i,
	input  wire logic [5:0]  offset_i,
	output logic      [15:0] eff_addr_o,
	output logic      [15:0] next_ptr_o
);

	logic [15:0] ptr_up;
	logic [15:0] ptr_dn;
	logic [15:0] offs_ext;

	always_comb begin
		// 16-bit sums drop the carry, so the pointer wraps both ways
		ptr_up   = ptr_i + smle_pkg::PTR_ONE;
		ptr_dn   = ptr_i - smle_pkg::PTR_ONE;
		offs_ext = {{(smle_pkg::PTR_W - smle_pkg::OFFS_W){offset_i[smle_pkg::OFFS_W - 1]}}, offset_i};
		if (rel_i) begin
			eff_addr_o = ptr_i + offs_ext;
			next_ptr_o = ptr_i;
		end else begin
			unique case (mode_i)
				smle_pkg::MODE_PRE_INC: begin
					eff_addr_o = ptr_up;
					next_ptr_o = ptr_up;
				end
				smle_pkg::MODE_PRE_DEC: begin
					eff_addr_o = ptr_dn;
					next_ptr_o = ptr_dn;
				end
				smle_pkg::MODE_POST_INC: begin
					eff_addr_o = ptr_i;
					next_ptr_o = ptr_up;
				end
				smle_pkg::MODE_POST_DEC: begin
					eff_addr_o = ptr_i;
					next_ptr_o = ptr_dn;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// file: smle_exec.sv
// smle_exec: executes logical right shift, move file, indirect load and three literal loads
// assumes: decode stage holds op and operands with a one-cycle issue strobe; file memory
// answers a read combinationally in the issue cycle; the core clock runs at 25 MHz
`timescale 1ns/1ns
`default_nettype none

// Function
// - shift right: result 6..0 from file bits 7..1, bit 7 zero, carry gets bit 0
// - destination selector 0 writes working register, 1 writes file register 0..127
// - move file copies value unchanged to destination and updates zero flag
// - indirect load mode code: pre-inc, pre-dec, post-inc, post-dec; result to W, zero
// - relative indirect load uses pointer plus signed offset -32..31, pointer kept
// - pointer ends one higher for increments, one lower for decrements, same for offset
// - indirect window addresses hold no data; accesses go to the pointer's location
// - file pointers are 16 bits and wrap modulo 65536
// - bank-select load stores literal 0..15 in bank select register, no flags changed
// - pc-latch load stores literal bits 6..0 into the upper program-counter latch, bit 7 dropped
// - literal load puts eight-bit literal in W, flags untouched, single cycle
// - pointer steps by indirect access leave all status flags alone
module smle_exec (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     issue_i,
	input  wire smle_pkg::smle_op_e       op_i,
	input  wire logic [6:0]               file_addr_i,
	input  wire logic                     dest_sel_i,
	input  wire logic                     ptr_sel_i,
	input  wire logic [1:0]               pointer_mode_code_i,
	input  wire logic                     relative_i,
	input  wire logic [5:0]               offset_i,
	input  wire logic [7:0]               literal_i,
	input  wire logic [7:0]               rd_data_i,
	output logic      [15:0]              rd_addr_o,
	output logic      [15:0]              wr_addr_o,
	output logic      [7:0]               wr_data_o,
	output logic                          wr_en_o,
	output logic      [7:0]               work_reg_o,
	output logic                          carry_o,
	output logic                          zero_o,
	output logic      [15:0]              file_pointer0_o,
	output logic      [15:0]              file_pointer1_o,
	output logic      [4:0]               bank_select_reg_o,
	output logic      [6:0]               pc_high_latch_o,
	output logic                          done_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == smle_pkg::DATA_ZERO);
	endfunction

	function automatic logic is_window(input logic [6:0] a);
		is_window = (a == smle_pkg::IND_WIN0_ADDR) || (a == smle_pkg::IND_WIN1_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// pointer arithmetic
	// ----------------------------------------------------------------
	logic [15:0] sel_ptr;
	logic [15:0] eff_addr;
	logic [15:0] stepped_ptr;

	assign sel_ptr = ptr_sel_i ? file_pointer1_o : file_pointer0_o;

	smle_ptr_step u_step (
		.ptr_i      (sel_ptr),
		.mode_i     (pointer_mode_code_i),
		.rel_i      (relative_i),
		.offset_i   (offset_i),
		.eff_addr_o (eff_addr),
		.next_ptr_o (stepped_ptr)
	);

	// ----------------------------------------------------------------
	// next-state computation
	// ----------------------------------------------------------------
	logic [15:0] file_addr_ext;
	logic [15:0] direct_addr;
	logic [7:0]  result;
	logic        file_result;

	logic [15:0] next_rd_addr;
	logic [15:0] next_wr_addr;
	logic [7:0]  next_wr_data;
	logic        next_wr_en;
	logic [7:0]  next_work_reg;
	logic        next_carry;
	logic        next_zero;
	logic [15:0] next_ptr0;
	logic [15:0] next_ptr1;
	logic [4:0]  next_bank;
	logic [6:0]  next_pch;
	logic        next_done;

	always_comb begin
		file_addr_ext = {{(smle_pkg::PTR_W - smle_pkg::ADDR_W){1'b0}}, file_addr_i};
		// window addresses are not storage: redirect to the pointer they name
		if (is_window(file_addr_i)) begin
			direct_addr = (file_addr_i == smle_pkg::IND_WIN1_ADDR) ?
				file_pointer1_o : file_pointer0_o;
		end else begin
			direct_addr = file_addr_ext;
		end
		result        = rd_data_i;
		file_result   = 1'b0;
		next_rd_addr  = rd_addr_o;
		next_wr_addr  = wr_addr_o;
		next_wr_data  = wr_data_o;
		next_wr_en    = 1'b0;
		next_work_reg = work_reg_o;
		next_carry    = carry_o;
		next_zero     = zero_o;
		next_ptr0     = file_pointer0_o;
		next_ptr1     = file_pointer1_o;
		next_bank     = bank_select_reg_o;
		next_pch      = pc_high_latch_o;
		next_done     = 1'b0;
		// the read address is only registered into rd_addr_o after the issue edge, this copy is for observation
		if (issue_i) begin
			next_done = 1'b1;
			unique case (op_i)
				smle_pkg::SMLE_OP_LSR: begin
					result      = {1'b0, rd_data_i[smle_pkg::MSB:1]};
					next_carry  = rd_data_i[smle_pkg::LSB];
					next_zero   = is_zero(result);
					file_result = 1'b1;
					next_rd_addr = direct_addr;
				end
				smle_pkg::SMLE_OP_MOVE_FILE: begin
					result      = rd_data_i;
					next_zero   = is_zero(result);
					file_result = 1'b1;
					next_rd_addr = direct_addr;
				end
				smle_pkg::SMLE_OP_IND_LOAD: begin
					next_rd_addr  = eff_addr;
					next_work_reg = rd_data_i;
					next_zero     = is_zero(rd_data_i);
					// pointer step itself touches no flag; zero comes from the data only
					if (ptr_sel_i) begin
						next_ptr1 = stepped_ptr;
					end else begin
						next_ptr0 = stepped_ptr;
					end
				end
				smle_pkg::SMLE_OP_LOAD_BANK: begin
					// high literal bits are dropped: operand range is 0..15
					next_bank = literal_i[4:0] & smle_pkg::BANK_LIT_MASK;
				end
				smle_pkg::SMLE_OP_LOAD_PCH: begin
					next_pch = literal_i[6:0];
				end
				smle_pkg::SMLE_OP_LOAD_WORK: begin
					next_work_reg = literal_i;
				end
				default: begin
					next_done = 1'b0;
				end
			endcase
			if (file_result) begin
				if (dest_sel_i == smle_pkg::DEST_WORK) begin
					next_work_reg = result;
				end else begin
					next_wr_en   = 1'b1;
					next_wr_addr = direct_addr;
					next_wr_data = result;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_addr_o         <= smle_pkg::PTR_RESET;
			wr_addr_o         <= smle_pkg::PTR_RESET;
			wr_data_o         <= smle_pkg::DATA_ZERO;
			wr_en_o           <= 1'b0;
			work_reg_o        <= smle_pkg::DATA_ZERO;
			carry_o           <= 1'b0;
			zero_o            <= 1'b0;
			file_pointer0_o   <= smle_pkg::PTR_RESET;
			file_pointer1_o   <= smle_pkg::PTR_RESET;
			bank_select_reg_o <= smle_pkg::BANK_RESET;
			pc_high_latch_o   <= smle_pkg::PCH_RESET;
			done_o            <= 1'b0;
		end else begin
			rd_addr_o         <= next_rd_addr;
			wr_addr_o         <= next_wr_addr;
			wr_data_o         <= next_wr_data;
			wr_en_o           <= next_wr_en;
			work_reg_o        <= next_work_reg;
			carry_o           <= next_carry;
			zero_o            <= next_zero;
			file_pointer0_o   <= next_ptr0;
			file_pointer1_o   <= next_ptr1;
			bank_select_reg_o <= next_bank;
			pc_high_latch_o   <= next_pch;
			done_o            <= next_done;
		end
	end

endmodule

`default_nettype wire

// file: smle_exec_monitor.sv
// smle_exec_monitor: port timing checks for the executor
// assumes: bound to smle_exec, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module smle_exec_monitor (
	input wire logic		clk_i,
	input wire logic		rst_i,
	input wire logic		issue_i,
	input wire smle_pkg::smle_op_e	op_i,
	input wire logic		dest_sel_i,
	input wire logic		ptr_sel_i,
	input wire logic		relative_i,
	input wire logic [1:0]		pointer_mode_code_i,
	input wire logic [7:0]		literal_i,
	input wire logic [7:0]		rd_data_i,
	input wire logic		wr_en_o,
	input wire logic [7:0]		wr_data_o,
	input wire logic [7:0]		work_reg_o,
	input wire logic		carry_o,
	input wire logic		zero_o,
	input wire logic [15:0]		file_pointer0_o,
	input wire logic [4:0]		bank_select_reg_o,
	input wire logic		done_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence take(smle_pkg::smle_op_e o);
		issue_i && op_i == o;
	endsequence
	sequence ptr0_step;
		issue_i && op_i == smle_pkg::SMLE_OP_IND_LOAD && !ptr_sel_i && !relative_i;
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	// the unused selector code above the literal loads must not report done
	done_on_op_a:
		assert property (issue_i |=> done_o == ($past(op_i) != smle_pkg::SMLE_OP_NONE &&
			$past(op_i) <= smle_pkg::SMLE_OP_LOAD_WORK)) else $error("done");
	quiet_idle_a:
		assert property (!issue_i |=> !done_o && !wr_en_o) else $error("idle");
	shift_res_a:
		assert property (take(smle_pkg::SMLE_OP_LSR) |=> carry_o == $past(rd_data_i[0]) &&
			(($past(dest_sel_i) ? wr_data_o : work_reg_o) == ($past(rd_data_i) >> 1))) else $error("shift");
	move_dest_a:
		assert property (take(smle_pkg::SMLE_OP_MOVE_FILE) |=> wr_en_o == $past(dest_sel_i) &&
			zero_o == ($past(rd_data_i) == 8'h00)) else $error("move");
	lit_flags_a:
		assert property (issue_i && op_i inside {smle_pkg::SMLE_OP_LOAD_BANK,
			smle_pkg::SMLE_OP_LOAD_PCH, smle_pkg::SMLE_OP_LOAD_WORK} |=> $stable({carry_o, zero_o}))
			else $error("flags");
	bank_load_a:
		assert property (take(smle_pkg::SMLE_OP_LOAD_BANK) |=>
			bank_select_reg_o == {1'h0, $past(literal_i[3:0])}) else $error("bank");
	ptr_step_a:
		assert property (ptr0_step |=> file_pointer0_o == ($past(pointer_mode_code_i[0]) ?
			$past(file_pointer0_o) - 16'h0001 : $past(file_pointer0_o) + 16'h0001)) else $error("step");
	ptr_rel_a:
		assert property (issue_i && op_i == smle_pkg::SMLE_OP_IND_LOAD && relative_i |=>
			$stable(file_pointer0_o))
			else $error("rel");
endmodule
bind smle_exec smle_exec_monitor u_mon (
	.clk_i               (clk_i),
	.rst_i               (rst_i),
	.issue_i             (issue_i),
	.op_i                (op_i),
	.dest_sel_i          (dest_sel_i),
	.ptr_sel_i           (ptr_sel_i),
	.relative_i          (relative_i),
	.pointer_mode_code_i (pointer_mode_code_i),
	.literal_i           (literal_i),
	.rd_data_i           (rd_data_i),
	.wr_en_o             (wr_en_o),
	.wr_data_o           (wr_data_o),
	.work_reg_o          (work_reg_o),
	.carry_o             (carry_o),
	.zero_o              (zero_o),
	.file_pointer0_o     (file_pointer0_o),
	.bank_select_reg_o   (bank_select_reg_o),
	.done_o              (done_o)
);
`default_nettype wire

// file: shift_move_literal_exec_bench.sv
// shift_move_literal_exec_bench: corner and random instruction stream against a model
// assumes: smle_exec answers an issue at the next edge
`timescale 1ns/1ns
`default_nettype none
module shift_move_literal_exec_bench;
	logic			clk_i = 1'h0, rst_i = 1'h1, issue_i = 1'h0;
	logic			dest_sel_i = 1'h0, ptr_sel_i = 1'h0, relative_i = 1'h0;
	logic [1:0]		pointer_mode_code_i = 2'h0;
	logic [5:0]		offset_i = 6'h00;
	logic [6:0]		file_addr_i = 7'h00;
	logic [7:0]		literal_i = 8'h00, rd_data_i = 8'h00;
	smle_pkg::smle_op_e	op_i = smle_pkg::SMLE_OP_NONE;
	logic [15:0]		rd_addr_o, wr_addr_o, file_pointer0_o, file_pointer1_o;
	logic [7:0]		wr_data_o, work_reg_o;
	logic [6:0]		pc_high_latch_o;
	logic [4:0]		bank_select_reg_o;
	logic			wr_en_o, carry_o, zero_o, done_o;
	logic [15:0]		p [2];
	logic [15:0]		ra, wa, np;
	logic [7:0]		w, wd, r;
	logic [6:0]		ph;
	logic [4:0]		bk;
	logic			c, z, we, dn;
	int			n_errors = 0, total_checks = 0;
	integer			seed = 32'h79452774;
	logic [31:0]		rv, rx;
	smle_exec dut (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.issue_i             (issue_i),
		.op_i                (op_i),
		.file_addr_i         (file_addr_i),
		.dest_sel_i          (dest_sel_i),
		.ptr_sel_i           (ptr_sel_i),
		.pointer_mode_code_i (pointer_mode_code_i),
		.relative_i          (relative_i),
		.offset_i            (offset_i),
		.literal_i           (literal_i),
		.rd_data_i           (rd_data_i),
		.rd_addr_o           (rd_addr_o),
		.wr_addr_o           (wr_addr_o),
		.wr_data_o           (wr_data_o),
		.wr_en_o             (wr_en_o),
		.work_reg_o          (work_reg_o),
		.carry_o             (carry_o),
		.zero_o              (zero_o),
		.file_pointer0_o     (file_pointer0_o),
		.file_pointer1_o     (file_pointer1_o),
		.bank_select_reg_o   (bank_select_reg_o),
		.pc_high_latch_o     (pc_high_latch_o),
		.done_o              (done_o)
	);
	// ----------------------------------------------------------------
	// expectation and checking
	// ----------------------------------------------------------------
	always #20 clk_i = ~clk_i;
	// window addresses read through the pointer they name
	function automatic logic [15:0] redir(input logic [6:0] a);
		if (a == smle_pkg::IND_WIN0_ADDR) return p[0];
		if (a == smle_pkg::IND_WIN1_ADDR) return p[1];
		return {9'h000, a};
	endfunction
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic run(input smle_pkg::smle_op_e op, input logic [6:0] a, input logic d, ps,
		input logic [1:0] m, input logic rel, input logic [5:0] off, input logic [7:0] lit, rdv);
		@(posedge clk_i);
		{op_i, file_addr_i, dest_sel_i, ptr_sel_i} <= {op, a, d, ps};
		{pointer_mode_code_i, relative_i, offset_i} <= {m, rel, off};
		{literal_i, rd_data_i, issue_i} <= {lit, rdv, 1'h1};
		@(posedge clk_i);
		issue_i <= 1'h0;
		we = 1'h0;
		dn = (op != smle_pkg::SMLE_OP_NONE) && (op <= smle_pkg::SMLE_OP_LOAD_WORK);
		case (op)
		smle_pkg::SMLE_OP_LSR, smle_pkg::SMLE_OP_MOVE_FILE: begin
			ra = redir(a);
			{r, c} = (op == smle_pkg::SMLE_OP_LSR) ? {1'h0, rdv} : {rdv, c};
			z = (r == 8'h00);
			{we, wa, wd} = {d, ra, r};
			if (!d) w = r;
		end
		smle_pkg::SMLE_OP_IND_LOAD: begin
			np = m[0] ? p[ps] - 16'h0001 : p[ps] + 16'h0001;
			ra = rel ? p[ps] + {{10{off[5]}}, off} : (m[1] ? p[ps] : np);
			if (!rel) p[ps] = np;
			{w, z} = {rdv, rdv == 8'h00};
		end
		smle_pkg::SMLE_OP_LOAD_BANK: bk = {1'h0, lit[3:0]};
		smle_pkg::SMLE_OP_LOAD_PCH: ph = lit[6:0];
		smle_pkg::SMLE_OP_LOAD_WORK: w = lit;
		default: ;
		endcase
		@(negedge clk_i);
		chk("ctl", {14'h0, wr_en_o, done_o}, {14'h0, we, dn});
		chk("flg", {2'h0, bank_select_reg_o, pc_high_latch_o, zero_o, carry_o}, {2'h0, bk, ph, z, c});
		chk("w", {8'h00, work_reg_o}, {8'h00, w});
		chk("p0", file_pointer0_o, p[0]);
		chk("p1", file_pointer1_o, p[1]);
		chk("ra", rd_addr_o, ra);
		if (we) begin
			chk("wa", wr_addr_o, wa);
			chk("wd", {8'h00, wr_data_o}, {8'h00, wd});
		end
	endtask
	initial begin
		{w, c, z, bk, ph, ra, p[0], p[1]} = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		// every mode on both pointers, wrapping both ways from zero
		for (int i = 0; i < 8; i++) begin
			run(smle_pkg::SMLE_OP_IND_LOAD, 7'h00, 1'h0, i[2], 2'(i + 1), 1'h0, 6'h00, 8'h00, 8'(i * 37));
		end
		run(smle_pkg::SMLE_OP_IND_LOAD, 7'h00, 1'h0, 1'h0, 2'h0, 1'h1, 6'h20, 8'h00, 8'h00);
		run(smle_pkg::SMLE_OP_IND_LOAD, 7'h00, 1'h0, 1'h1, 2'h3, 1'h1, 6'h1F, 8'h00, 8'h5A);
		run(smle_pkg::SMLE_OP_LSR, 7'h01, 1'h1, 1'h0, 2'h0, 1'h0, 6'h00, 8'h00, 8'h81);
		run(smle_pkg::SMLE_OP_LSR, 7'h7F, 1'h0, 1'h0, 2'h0, 1'h0, 6'h00, 8'h00, 8'h01);
		run(smle_pkg::SMLE_OP_MOVE_FILE, 7'h7F, 1'h1, 1'h0, 2'h0, 1'h0, 6'h00, 8'h00, 8'h00);
		run(smle_pkg::SMLE_OP_LOAD_BANK, 7'h00, 1'h0, 1'h0, 2'h0, 1'h0, 6'h00, 8'hFF, 8'h00);
		run(smle_pkg::SMLE_OP_LOAD_PCH, 7'h00, 1'h0, 1'h0, 2'h0, 1'h0, 6'h00, 8'hFF, 8'h00);
		run(smle_pkg::SMLE_OP_NONE, 7'h00, 1'h1, 1'h0, 2'h0, 1'h0, 6'h00, 8'h33, 8'h00);
		// the unused selector code must behave like no operation
		run(smle_pkg::smle_op_e'(3'h7), 7'h01, 1'h1, 1'h1, 2'h0, 1'h0, 6'h00, 8'h33, 8'h00);
		repeat (400) begin
			rv = $random(seed);
			rx = $random(seed);
			run(smle_pkg::smle_op_e'(rv[2:0] % 3'h7), rv[9:3], rv[10], rv[11], rv[13:12], rv[14],
				rv[20:15], rv[28:21], rx[7:0]);
		end
		complete_run();
	end
endmodule
`default_nettype wire
